//--- hw/sesl_pkg.sv
// shared constants and carrier types for the switch event status latch
package sesl_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] PRIMARY_STATUS_OFS = 8'h01;
  localparam logic [7:0] EVENT_STATUS_OFS   = 8'h07;
  localparam logic [7:0] EVENT_STATUS_RST   = 8'h00;

  // ----------------------------------------------------------------
  // event status field positions
  // ----------------------------------------------------------------
  localparam int SEL_CHG_BIT    = 5;
  localparam int CLKDET_CHG_BIT = 4;
  localparam int SUPPLY_CHG_LSB = 0;
  localparam int NUM_PORTS      = 4;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] sel_port;
    logic       clk_detect;
    logic [3:0] port_supply_sense;
  } sesl_sense_s;

  typedef struct packed {
    logic       done;
    logic [7:0] addr;
  } sesl_rd_s;

endpackage

//--- hw/sesl_latch.sv
// event change status latch with interrupt and read acknowledge
// ----------------------------------------------------------------
// Function
// - bit 5 flags a change of the selected port since last primary read
// - bit 4 flags a change of selected port clock detect since last primary read
// - bits 3..0 flag supply sense changes on ports 4, 3, 2, 1
// - all flags zero after reset; bits 7 and 6 always read zero
// - event status register is read only; host never writes it
// - flags are captured into the register when the interrupt rises
// - reading primary status clears interrupt and all captured flags
// - while primary status is unread, flags keep accumulating further events
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module sesl_latch #(
  parameter int NUM_PORTS = 4
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire sesl_pkg::sesl_sense_s sense,
  input  wire sesl_pkg::sesl_rd_s    rd,
  output logic [7:0]                 event_status_ff,
  output logic                       irq_ff
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (NUM_PORTS != sesl_pkg::NUM_PORTS)
  begin : g_bad_ports
    $error("sesl_latch serves exactly four ports");
  end

  // ----------------------------------------------------------------
  // change detection
  // ----------------------------------------------------------------
  sesl_pkg::sesl_sense_s prev_ff;
  logic                  primed_ff;
  logic [5:0]            chg;
  logic [NUM_PORTS-1:0]  supply_chg;
  logic                  ack;
  logic [7:0]            nxt_event_status;
  logic                  nxt_irq;

  // prev is reset to a constant, so the first sample after reset is
  // only stored; primed blocks a false change on that cycle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prev_ff   <= '0;
      primed_ff <= 1'b0;
    end
    else
    begin
      prev_ff   <= sense;
      primed_ff <= 1'b1;
    end
  end

  // per port supply change, one lane per port
  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_supply_chg
    assign supply_chg[p] = primed_ff
      && (sense.port_supply_sense[p] != prev_ff.port_supply_sense[p]);
  end

  always_comb
  begin
    chg = '0;
    if (primed_ff)
    begin
      chg[sesl_pkg::SEL_CHG_BIT] = (sense.sel_port != prev_ff.sel_port);
      chg[sesl_pkg::CLKDET_CHG_BIT] = (sense.clk_detect != prev_ff.clk_detect);
    end
    // supply lanes, already gated by primed
    chg[sesl_pkg::SUPPLY_CHG_LSB +: NUM_PORTS] = supply_chg;
  end

  // ----------------------------------------------------------------
  // acknowledge and latch
  // ----------------------------------------------------------------
  // primary read acknowledge
  assign ack = rd.done && (rd.addr == sesl_pkg::PRIMARY_STATUS_OFS);

  always_comb
  begin
    // clear on acknowledge, new event still wins over the clear
    nxt_event_status = ack ? sesl_pkg::EVENT_STATUS_RST : event_status_ff;
    nxt_irq          = ack ? 1'b0 : irq_ff;
    nxt_event_status[5:0] = nxt_event_status[5:0] | chg;
    nxt_event_status[7:6] = 2'h0;
    nxt_irq = nxt_irq | (|chg);
  end

  // captured on the same edge the interrupt rises
  // no write path reaches this register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      event_status_ff <= sesl_pkg::EVENT_STATUS_RST;
      irq_ff          <= 1'b0;
    end
    else
    begin
      event_status_ff <= nxt_event_status;
      irq_ff          <= nxt_irq;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // acknowledge with nothing new seen on the same edge
  sequence ack_s;
    ack && (chg == 6'h00);
  endsequence

  // acknowledge racing a fresh change; the change must survive
  sequence ack_race_s;
    ack && (chg != 6'h00);
  endsequence

  // neither acknowledge nor change
  sequence quiet_s;
    !ack && (chg == 6'h00);
  endsequence

  // completed read of any other offset, nothing new seen
  sequence other_rd_s;
    rd.done && (rd.addr != sesl_pkg::PRIMARY_STATUS_OFS) && (chg == 6'h00);
  endsequence

  // ----------------------------------------------------------------
  // assertions: reset and reserved bits
  // ----------------------------------------------------------------
  rsvd_bits_zero_a: assert property (event_status_ff[7:6] == 2'h0)
    else $error("reserved event bits not zero");

  // held reset must clear, so this one is never disabled
  reset_clears_a: assert property (@(posedge clk) disable iff (1'h0)
    rst |=> (event_status_ff == 8'h00) && !irq_ff)
    else $error("reset did not clear flags");

  // the history reset value must not look like a change after release
  prime_quiet_a: assert property ($fell(rst) |->
    ({irq_ff, event_status_ff} == 9'h000) ##1 ({irq_ff, event_status_ff} == 9'h000))
    else $error("false change after reset release");

  // ----------------------------------------------------------------
  // assertions: change capture
  // ----------------------------------------------------------------
  sel_change_a: assert property (primed_ff && (sense.sel_port != prev_ff.sel_port)
    |=> event_status_ff[5] && irq_ff)
    else $error("port select change lost");

  clkdet_change_a: assert property (
    primed_ff && (sense.clk_detect != prev_ff.clk_detect) |=> event_status_ff[4] && irq_ff)
    else $error("clock detect change lost");

  supply_change_a: assert property (primed_ff |=>
    ((event_status_ff[3:0] & $past(chg[3:0])) == $past(chg[3:0])))
    else $error("supply sense change lost");

  // one check per lane, so a swapped port order is caught by lane
  for (genvar q = 0; q < NUM_PORTS; q++)
  begin : g_supply_chk
    supply_lane_a: assert property (@(posedge clk) disable iff (rst)
      primed_ff && (sense.port_supply_sense[q] != prev_ff.port_supply_sense[q])
      |=> event_status_ff[sesl_pkg::SUPPLY_CHG_LSB + q])
      else $error("supply lane flag missing");
  end

  capture_a: assert property ($rose(irq_ff) |-> (event_status_ff[5:0] != 6'h00))
    else $error("interrupt rose with empty latch");

  irq_cause_a: assert property ($rose(irq_ff) |-> $past(chg != 6'h00))
    else $error("interrupt rose without change");

  // interrupt and latch are set and cleared together, never apart
  irq_tracks_a: assert property (irq_ff == (event_status_ff[5:0] != 6'h00))
    else $error("interrupt and latch disagree");

  accumulate_a: assert property (!ack |=>
    ((event_status_ff & $past(event_status_ff)) == $past(event_status_ff)))
    else $error("flags dropped while unread");

  no_write_a: assert property (quiet_s |=> $stable(event_status_ff))
    else $error("event status changed without event");

  // ----------------------------------------------------------------
  // assertions: acknowledge
  // ----------------------------------------------------------------
  ack_clears_a: assert property (ack_s |=> (event_status_ff == 8'h00) && !irq_ff)
    else $error("primary read did not clear");

  // set wins: a change on the acknowledge edge is all that remains
  ack_race_a: assert property (ack_race_s |=>
    (event_status_ff[5:0] == $past(chg)) && irq_ff)
    else $error("change lost under acknowledge");

  ack_pulse_a: assert property (ack_s ##1 quiet_s |-> !irq_ff ##1 !irq_ff)
    else $error("interrupt came back without event");

  // reading the event status itself must not acknowledge
  other_read_a: assert property (other_rd_s |=>
    $stable(event_status_ff) && $stable(irq_ff))
    else $error("read of another offset changed the latch");

endmodule // sesl_latch

`default_nettype wire

//--- verif/sesl_host_model.sv
// host model issuing completed register reads to the latch
`timescale 1ns/1ps
`default_nettype none
module sesl_host_model (
  input  wire logic          clk,
  input  wire logic [7:0]    status,
  output var  sesl_pkg::sesl_rd_s rd
);
  initial rd = '0;
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    rd   = {1'b1, addr};
    data = status;
    @(negedge clk);
    // released address shows inverse, so a stale value cannot pass
    rd   = {1'b0, ~addr};
    // one idle cycle keeps back to back reads apart
    @(negedge clk);
  endtask
endmodule // sesl_host_model
`default_nettype wire

//--- verif/tb_sesl_latch.sv
// testbench for the switch event status latch
`timescale 1ns/1ps
`default_nettype none
module tb_sesl_latch;
  // ----------------------------------------------------------------
  // clock, reset and wiring
  // ----------------------------------------------------------------
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  sesl_pkg::sesl_sense_s sense = '0;
  sesl_pkg::sesl_rd_s    rd;
  logic [7:0]            status;
  logic                  irq;
  logic [7:0]            rdata;
  int                    miscompares = 0;
  int                    tests_run = 0;
  always #25 clk = ~clk;
  sesl_latch #(.NUM_PORTS(4)) i_sesl_latch (.clk(clk), .rst(rst), .sense(sense),
    .rd(rd), .event_status_ff(status), .irq_ff(irq));
  sesl_host_model i_sesl_host_model (.clk(clk), .status(status), .rd(rd));
  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (miscompares == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // sense bit k maps onto flag bit k, so one loop covers all six sources
  task automatic t_single();
    for (int k = 0; k < 6; k++)
    begin
      sense = sesl_pkg::sesl_sense_s'(sense ^ 7'(1 << k));
      @(negedge clk);
      check("flag", status, 8'(1 << k));
      check("irq", {7'h00, irq}, 8'h01);
      i_sesl_host_model.read_reg(sesl_pkg::PRIMARY_STATUS_OFS, rdata);
      check("clear", status, 8'h00);
      check("irq clear", {7'h00, irq}, 8'h00);
    end
  endtask
  task automatic t_accum();
    sense = sesl_pkg::sesl_sense_s'(sense ^ 7'h01);
    @(negedge clk);
    sense = sesl_pkg::sesl_sense_s'(sense ^ 7'h08);
    @(negedge clk);
    i_sesl_host_model.read_reg(sesl_pkg::EVENT_STATUS_OFS, rdata);
    check("accum", rdata, 8'h09);
    check("debug read", status, 8'h09);
    // change on the acknowledge edge must survive the clear
    sense = sesl_pkg::sesl_sense_s'(sense ^ 7'h02);
    i_sesl_host_model.read_reg(sesl_pkg::PRIMARY_STATUS_OFS, rdata);
    check("set wins", status, 8'h02);
    check("irq held", {7'h00, irq}, 8'h01);
    i_sesl_host_model.read_reg(sesl_pkg::PRIMARY_STATUS_OFS, rdata);
    check("final", {irq, status[6:0]}, 8'h00);
  endtask
  // reset with a flag pending; after release sense is far from the reset
  // history value, yet the first sample only primes
  task automatic t_reset();
    sense = sesl_pkg::sesl_sense_s'(sense ^ 7'h10);
    @(negedge clk);
    check("pre reset", status, 8'h10);
    rst = 1'b1;
    repeat (5) @(negedge clk);
    check("mid reset", {irq, status[6:0]}, sesl_pkg::EVENT_STATUS_RST);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    check("prime", {irq, status[6:0]}, 8'h00);
  endtask
  initial
  begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    check("reset", status, sesl_pkg::EVENT_STATUS_RST);
    check("irq reset", {7'h00, irq}, 8'h00);
    t_single();
    t_accum();
    t_reset();
    complete_run();
  end
  // about 40 cycles expected; generous margin
  initial
  begin
    #(50 * 2000);
    miscompares++;
    complete_run();
  end
endmodule // tb_sesl_latch
`default_nettype wire
